//--- verilog/pickup_stage.sv
// pickup_stage: pick-up comparator, inhibit gating and operate delay of one stage.
// assumes an APB master on pclk, a measurement sample held stable by the front end,
// and an asynchronous inhibit level from the routing matrix.
//
// Contract
// RL1: compare measured magnitude against pick-up level; assert pick-up when reached.
// RL2: release pick-up below 97 percent of the set level, not the measurement.
// RL3: sample inhibit input at the start of every program cycle before evaluation.
// RL4: pick-up without inhibit asserts start and begins operate delay evaluation.
// RL5: pick-up with inhibit asserts blocked indication and stops further processing.
// RL6: inhibit during start clears start and releases as on pick-up reset.
// RL7: inhibition logs a time-stamped event with start magnitude and fault type; the logged event holds no time stamp.
// RL8: inhibit source presents inhibit at least 5 ms before delay expiry.
// RL9: instant mode asserts trip together with start, no added delay.
// RL10: fixed delay mode trips after set delay while pick-up stays active.
// RL11: inverse delay mode trips after delay derived from magnitude over pick-up.
// RL12: inverse delay mode never trips before fixed delay; zero disables floor.
// RL13: inverse curves of both families plus a user-parameterised curve.
// RL14: delay type selector chooses fixed or inverse, default fixed.
// RL15: fixed delay set in 5 ms steps, default 40 ms.
// RL16: fixed delay zero operates instantly; nonzero gives delayed operation.
// RL17: curve family selector, default first family, used only in inverse mode.
// RL18: pick-up release before trip clears accumulator and deasserts start.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pickup_stage
    import pickup_pkg::*;
#(
    parameter int unsigned PROG_CYCLE_CLKS_P = PROG_CYCLE_CLKS
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  meas_t            meas,
    input  wire logic        inhibit_pin,
    output logic             pickup,
    output logic             start,
    output logic             trip,
    output logic             blocked,
    output logic             evt_valid,
    output meas_t            evt
);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] release_level(input logic [15:0] set_level);
        logic [23:0] prod;
        prod = 24'(set_level) * 24'(RESET_RATIO_PCT);
        return 16'(prod / 24'(FULL_PCT));
    endfunction

    function automatic logic [31:0] read_mux(input core_state_t c, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            OFS_CTRL:       d = 32'({c.cfg.param, c.cfg.ieee, c.cfg.inverse});
            OFS_PICKUP:     d = 32'(c.cfg.pickup);
            OFS_FIXED_DLY:  d = 32'(c.cfg.fixed_dly);
            OFS_INV_TARGET: d = c.cfg.inv_target;
            OFS_INV_GAIN:   d = 32'(c.cfg.inv_gain);
            OFS_STATUS:     d = 32'({c.st, c.blk, c.pick});
            OFS_EVENT:      d = 32'(c.evt);
            default:        d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_PICKUP) || (a == OFS_FIXED_DLY) ||
               (a == OFS_INV_TARGET) || (a == OFS_INV_GAIN) || (a == OFS_STATUS) ||
               (a == OFS_EVENT);
    endfunction

    // ************************************************************
    // state and support signals
    // ************************************************************
    core_state_t  s;
    core_state_t  next_s;
    logic         inhibit_level;
    logic [31:0]  inc;
    logic         tick;
    logic         pick_now;
    logic [23:0]  dly_cycles;
    logic [23:0]  e1;
    logic [31:0]  a1;
    logic         due;
    logic         wr_en;

    inhibit_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (inhibit_pin),
        .level   (inhibit_level)
    );

    inverse_rate u_rate (
        .cfg       (s.cfg),
        .magnitude (meas.magnitude),
        .inc       (inc)
    ); // [RL11] [RL13]

    assign tick       = (s.tick_cnt == 16'(PROG_CYCLE_CLKS_P - 1));
    assign dly_cycles = 24'(s.cfg.fixed_dly) * 24'(CYCLES_PER_STEP); // [RL15]
    assign e1         = s.elapsed + 24'h000001;
    assign a1         = s.acc + inc;
    assign wr_en      = psel && penable && pwrite;

    // hysteresis is held against the set level so noise on the sample cannot chatter
    always_comb begin
        if (s.pick) begin
            pick_now = (meas.magnitude >= release_level(s.cfg.pickup)); // [RL2]
        end else begin
            pick_now = (meas.magnitude >= s.cfg.pickup); // [RL1]
        end
    end

    // fixed mode trips on the exact delay; inverse mode also waits for the floor
    always_comb begin
        if (s.cfg.inverse) begin
            due = (a1 >= s.cfg.inv_target) && (e1 >= dly_cycles); // [RL11] [RL12] [RL17]
        end else begin
            due = (e1 >= dly_cycles); // [RL10] [RL16]
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_s           = s;
        next_s.evt_valid = 1'b0;
        next_s.tick_cnt  = tick ? 16'h0000 : s.tick_cnt + 16'h0001;

        // register port: read data is prepared in the setup phase
        if (psel && !penable) begin
            next_s.prdata = read_mux(s, paddr);
        end
        if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: begin
                    next_s.cfg.inverse = pwdata[CTRL_INV_POS]; // [RL14]
                    next_s.cfg.ieee    = pwdata[CTRL_IEEE_POS];
                    next_s.cfg.param   = pwdata[CTRL_PARAM_POS];
                end
                OFS_PICKUP:     next_s.cfg.pickup     = pwdata[15:0];
                OFS_FIXED_DLY:  next_s.cfg.fixed_dly  = pwdata[18:0];
                OFS_INV_TARGET: next_s.cfg.inv_target = pwdata;
                OFS_INV_GAIN:   next_s.cfg.inv_gain   = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // stage evaluation once per program cycle
        if (tick) begin
            next_s.blk  = inhibit_level; // [RL3]
            next_s.pick = pick_now;
            unique case (s.st)
                ST_IDLE: begin
                    if (pick_now && inhibit_level) begin
                        next_s.st        = ST_BLOCKED; // [RL5]
                        next_s.evt       = meas; // [RL7]
                        next_s.evt_valid = 1'b1;
                    end else if (pick_now) begin
                        next_s.start_meas = meas;
                        next_s.elapsed    = 24'h000000;
                        next_s.acc        = 32'h0000_0000;
                        if (!s.cfg.inverse && dly_cycles == 24'h000000) begin
                            next_s.st = ST_TRIP; // [RL9] [RL16]
                        end else begin
                            next_s.st = ST_START; // [RL4]
                        end
                    end
                end
                ST_START: begin
                    if (!pick_now) begin
                        next_s.st      = ST_IDLE; // [RL18]
                        next_s.elapsed = 24'h000000;
                        next_s.acc     = 32'h0000_0000;
                    end else if (inhibit_level) begin
                        // inhibit arriving after start still logs the start-up sample
                        next_s.st        = ST_BLOCKED; // [RL6]
                        next_s.evt       = s.start_meas; // [RL7]
                        next_s.evt_valid = 1'b1;
                        next_s.elapsed   = 24'h000000;
                        next_s.acc       = 32'h0000_0000;
                    end else begin
                        next_s.elapsed = e1;
                        next_s.acc     = s.cfg.inverse ? a1 : 32'h0000_0000;
                        if (due) begin
                            next_s.st = ST_TRIP;
                        end
                    end
                end
                ST_TRIP: begin
                    if (!pick_now) begin
                        next_s.st      = ST_IDLE;
                        next_s.elapsed = 24'h000000;
                        next_s.acc     = 32'h0000_0000;
                    end
                end
                ST_BLOCKED: begin
                    // blocked stays until pick-up drops; no delay runs meanwhile
                    if (!pick_now) begin
                        next_s.st = ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s                <= '0;
            s.st             <= ST_IDLE;
            s.cfg.pickup     <= RST_PICKUP;
            s.cfg.fixed_dly  <= RST_FIXED_DLY;
            s.cfg.inv_target <= RST_INV_TARGET;
            s.cfg.inv_gain   <= RST_INV_GAIN;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata    = s.prdata;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped(paddr);
    assign pickup    = s.pick;
    assign start     = (s.st == ST_START) || (s.st == ST_TRIP);
    assign trip      = (s.st == ST_TRIP);
    assign blocked   = (s.st == ST_BLOCKED);
    assign evt_valid = s.evt_valid;
    assign evt       = s.evt;

    // ************************************************************
    // assertions
    // ************************************************************
    a_trip_needs_start: assert property ( // [RL9]
        trip |-> start)
        else $error("trip without start");

    a_block_clears_start: assert property ( // [RL6]
        $rose(blocked) |-> !start && !trip && s.acc == 32'h0000_0000)
        else $error("start survives inhibit");

    a_block_logs_event: assert property ( // [RL7]
        $rose(blocked) |-> evt_valid ##1 !evt_valid)
        else $error("inhibit without single event pulse");

    a_instant_trip: assert property ( // [RL16]
        ($rose(start) && !s.cfg.inverse && dly_cycles == 24'h000000) |-> trip)
        else $error("instant mode did not trip with start");

    a_fixed_exact: assert property ( // [RL10]
        ($rose(trip) && !s.cfg.inverse) |-> s.elapsed == dly_cycles)
        else $error("fixed delay trip at wrong time");

    a_inverse_floor: assert property ( // [RL12]
        ($rose(trip) && s.cfg.inverse) |-> s.elapsed >= dly_cycles && s.acc >= s.cfg.inv_target)
        else $error("inverse trip before floor or target");

    a_release_clears: assert property ( // [RL18]
        (s.st == ST_IDLE) |-> (s.acc == 32'h0000_0000 && s.elapsed == 24'h000000))
        else $error("accumulator not cleared on release");

    a_eval_on_tick: assert property ( // [RL3]
        (s.st != $past(s.st)) |-> $past(tick))
        else $error("stage state moved outside program cycle start");

    a_blocked_quiet: assert property ( // [RL5]
        blocked |-> !start && s.elapsed == 24'h000000 && s.acc == 32'h0000_0000)
        else $error("delay runs while blocked");

    a_hyst_release: assert property ( // [RL2]
        $fell(pickup) |-> $past(tick) && $past(meas.magnitude) < release_level($past(s.cfg.pickup)))
        else $error("pick-up released above reset level");

    a_pick_rise: assert property ( // [RL1]
        tick && !pickup && meas.magnitude >= s.cfg.pickup |=> pickup)
        else $error("no pick-up at level");

    a_hyst_hold: assert property ( // [RL2]
        tick && pickup && meas.magnitude >= release_level(s.cfg.pickup) |=> pickup)
        else $error("early release");

    a_inhibit_sample: assert property ( // [RL3]
        tick |=> s.blk == $past(inhibit_level))
        else $error("inhibit not sampled");

    a_start_free: assert property ( // [RL4]
        tick && s.st == ST_IDLE && pick_now && !inhibit_level
            |=> start && !blocked)
        else $error("no start");

    a_block_pick: assert property ( // [RL5]
        tick && s.st == ST_IDLE && pick_now && inhibit_level
            |=> blocked && !start)
        else $error("no blocked state");

    a_inhibit_start: assert property ( // [RL6]
        tick && s.st == ST_START && pick_now && inhibit_level
            |=> blocked && !start)
        else $error("start kept on inhibit");

    a_event_idle: assert property ( // [RL7]
        evt_valid && !$past(start) |-> evt == $past(meas))
        else $error("bad event sample");

    a_event_start: assert property ( // [RL7]
        evt_valid && $past(start) |-> evt == s.start_meas)
        else $error("bad start-up sample");

    a_trip_pickup: assert property ( // [RL10]
        trip |-> pickup)
        else $error("trip without pick-up");

    a_fixed_step: assert property ( // [RL10]
        tick && s.st == ST_START && pick_now && !inhibit_level
            |=> s.elapsed == $past(s.elapsed) + 24'h000001)
        else $error("delay count stuck");

    a_inverse_step: assert property ( // [RL11]
        tick && s.st == ST_START && pick_now && !inhibit_level && s.cfg.inverse
            |=> s.acc == $past(s.acc) + $past(inc))
        else $error("accumulator stuck");

    a_family_idle: assert property ( // [RL17]
        tick && s.st == ST_START && !s.cfg.inverse |=> s.acc == 32'h0000_0000)
        else $error("curve used in fixed mode");

endmodule

//--- verilog/pickup_pkg.sv
// pickup_pkg: constants, register map and carrier types of the pick-up/delay stage.
// assumes a 40 MHz pclk and a 32-bit APB register port.
package pickup_pkg;

    // ************************************************************
    // clock and program cycle timing
    // ************************************************************
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned PROG_CYCLE_US     = 1000;
    localparam int unsigned PROG_CYCLE_CLKS   = (CLK_HZ / 1_000_000) * PROG_CYCLE_US;
    localparam int unsigned DELAY_STEP_MS     = 5;
    localparam int unsigned CYCLES_PER_STEP   = (DELAY_STEP_MS * 1000) / PROG_CYCLE_US;
    localparam int unsigned INHIBIT_LEAD_MS   = 5;
    localparam int unsigned RESET_RATIO_PCT   = 97;
    localparam int unsigned FULL_PCT          = 100;

    // ************************************************************
    // register map (byte offsets)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_PICKUP     = 8'h04;
    localparam logic [7:0] OFS_FIXED_DLY  = 8'h08;
    localparam logic [7:0] OFS_INV_TARGET = 8'h0C;
    localparam logic [7:0] OFS_INV_GAIN   = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;
    localparam logic [7:0] OFS_EVENT      = 8'h18;

    localparam int unsigned CTRL_INV_POS   = 0;
    localparam int unsigned CTRL_IEEE_POS  = 1;
    localparam int unsigned CTRL_PARAM_POS = 2;

    localparam logic [15:0] RST_PICKUP     = 16'h0100;
    localparam logic [18:0] RST_FIXED_DLY  = 19'h00008;
    localparam logic [31:0] RST_INV_TARGET = 32'h0001_0000;
    localparam logic [7:0]  RST_INV_GAIN   = 8'h10;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_START   = 2'b01,
        ST_TRIP    = 2'b10,
        ST_BLOCKED = 2'b11
    } stage_state_t;

    typedef struct packed {
        logic        inverse;
        logic        ieee;
        logic        param;
        logic [15:0] pickup;
        logic [18:0] fixed_dly;
        logic [31:0] inv_target;
        logic [7:0]  inv_gain;
    } cfg_t;

    typedef struct packed {
        logic [1:0]  fault_type;
        logic [15:0] magnitude;
    } meas_t;

    typedef struct packed {
        cfg_t         cfg;
        logic [15:0]  tick_cnt;
        logic         pick;
        logic         blk;
        stage_state_t st;
        logic [23:0]  elapsed;
        logic [31:0]  acc;
        meas_t        start_meas;
        meas_t        evt;
        logic         evt_valid;
        logic [31:0]  prdata;
    } core_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

endpackage

//--- verilog/inhibit_sync.sv
// inhibit_sync: brings the external inhibit level into the pclk domain.
// assumes the inhibit pin is asynchronous to pclk.
`timescale 1ns/1ps
module inhibit_sync
    import pickup_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      level
);

    sync_state_t s;
    sync_state_t next_s;

    // a change is accepted only once the second and third stage agree
    always_comb begin
        next_s       = s;
        next_s.s1    = pin;
        next_s.s2    = s.s1;
        next_s.s3    = s.s2;
        if (s.s2 == s.s3) begin
            next_s.level = s.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;

endmodule

//--- verilog/inverse_rate.sv
// inverse_rate: per program cycle increment of the inverse-time accumulator.
// assumes magnitude and pick-up level share one scale.
`timescale 1ns/1ps
module inverse_rate
    import pickup_pkg::*;
(
    input  cfg_t             cfg,
    input  wire logic [15:0] magnitude,
    output logic [31:0]      inc
);

    logic [16:0] excess;
    logic [24:0] scaled;

    // larger overshoot gives a faster rise, so the trip time falls as the ratio grows
    always_comb begin
        excess = (magnitude > cfg.pickup) ? {1'b0, magnitude - cfg.pickup} : 17'h00000;
        scaled = 25'(excess) * 25'(cfg.inv_gain);
        if (cfg.param) begin
            inc = 32'(scaled[24:4]);
        end else if (cfg.ieee) begin
            inc = 32'(excess) + 32'(excess[16:2]);
        end else begin
            inc = 32'(excess);
        end
    end

endmodule

//--- bench/meas_source.sv
// meas_source: model of the measurement front end and of the inhibit routing matrix.
// assumes bench commands change just after a pclk edge; outputs are registered on pclk.
`timescale 1ns/1ps
module meas_source
    import pickup_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] mag_cmd,
    input  wire logic [1:0]  fault_cmd,
    input  wire logic        inh_cmd,
    output meas_t            meas,
    output logic             inhibit_pin
);
    // ************************************************************
    // sample and hold
    // ************************************************************
    // a sample stands until the next command, so the stage never sees a half-updated value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas        <= '0;
            inhibit_pin <= 1'b0;
        end else begin
            meas        <= '{fault_type: fault_cmd, magnitude: mag_cmd};
            // the bench raises inhibit far more than 5 ms before any delay runs out
            inhibit_pin <= inh_cmd;
        end
    end
endmodule

//--- bench/tb.sv
// tb: self-checking bench of pickup_stage, run with a short program cycle.
// assumes meas_source as the far side and the bench as APB master on pclk.
`timescale 1ns/1ps
module tb
    import pickup_pkg::*;
;
    localparam int CYC = 8;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] mag_cmd = 16'h0;
    logic [1:0]  fault_cmd = 2'h0;
    logic        inh_cmd = 1'b0;
    meas_t       meas;
    logic        inhibit_pin;
    logic        pickup, start, trip, blocked, evt_valid;
    meas_t       evt;
    meas_t       evt_last;
    int          evt_cnt = 0;
    int          fail_count = 0;
    int          n_compared = 0;
    logic [3:0]  outs;
    logic [7:0]  ra [6] = '{OFS_CTRL, OFS_PICKUP, OFS_FIXED_DLY, OFS_INV_TARGET, OFS_INV_GAIN, OFS_STATUS};
    // fixed delay default: 40 ms in 5 ms steps
    logic [31:0] rv [6] = '{32'h0, 32'h100, 32'h8, 32'h1_0000, 32'h10, 32'h0};
    int          ic [5] = '{1, 1, 3, 5, 1};
    int          ig [5] = '{16, 16, 16, 32, 16};
    int          ix [5] = '{64, 32, 32, 32, 2048};
    int          id [5] = '{0, 0, 0, 0, 1};

    assign outs = {blocked, trip, start, pickup};
    always #12.5 pclk = ~pclk;

    pickup_stage #(.PROG_CYCLE_CLKS_P(CYC)) pickup_stage_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas(meas), .inhibit_pin(inhibit_pin), .pickup(pickup), .start(start), .trip(trip),
        .blocked(blocked), .evt_valid(evt_valid), .evt(evt)
    );
    meas_source meas_source_inst (
        .pclk(pclk), .presetn(presetn), .mag_cmd(mag_cmd), .fault_cmd(fault_cmd),
        .inh_cmd(inh_cmd), .meas(meas), .inhibit_pin(inhibit_pin)
    );

    // ************************************************************
    // event log and helpers
    // ************************************************************
    always @(posedge pclk) begin
        if (evt_valid === 1'b1) begin
            evt_cnt  <= evt_cnt + 1;
            evt_last <= evt;
        end
    end

    task automatic end_of_test();
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // wait states are allowed: the access phase lasts until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        check("register read", exp, rd);
    endtask

    task automatic drive(input logic [15:0] m, input logic [1:0] f, input logic h);
        @(posedge pclk);
        mag_cmd   <= m;
        fault_cmd <= f;
        inh_cmd   <= h;
    endtask

    task automatic wait_ticks(input int t);
        repeat (t * CYC) @(posedge pclk);
    endtask

    task automatic wait_bit(input int b, input logic v, output int n);
        n = 1;
        @(negedge pclk);
        while (outs[b] !== v && n < 4000) begin
            @(negedge pclk);
            n++;
        end
        check("awaited output level", 32'(v), 32'(outs[b]));
    endtask

    // cycles from start rising to trip rising
    task automatic measure(output int dt);
        int n;
        wait_bit(1, 1'b1, n);
        dt = 0;
        if (trip !== 1'b1) begin
            wait_bit(2, 1'b1, n);
            dt = n;
        end
    endtask

    task automatic settle();
        drive(16'h0000, 2'h0, 1'b0);
        wait_ticks(3);
        check("outputs idle", 32'h0, {28'h0, outs});
    endtask

    // ticks to reach a target of 0x100 with the curve's increment, floored by the fixed delay
    function automatic int inv_ticks(int c, int g, int x, int d);
        int inc;
        int k;
        inc = c[2] ? (x * g) >> 4 : (c[1] ? x + (x >> 2) : x);
        k = (32'h100 + inc - 1) / inc;
        return (k > d * 5) ? k : d * 5;
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        logic [31:0] d;
        logic        e;
        int          dt, lo, ev, n;
        logic [15:0] m;
        void'($urandom(32'h17E7));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk(ra[i], rv[i]);
        apb(1'b0, 8'h1C, 32'h0, d, e);
        check("unmapped error", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, d);
        wr(OFS_STATUS, 32'hF);
        rdchk(OFS_STATUS, 32'h0);
        drive(16'h00FF, 2'h0, 1'b0);
        wait_ticks(2);
        check("below level", 32'h0, {28'h0, outs});
        drive(16'h0100, 2'h0, 1'b0);
        wait_bit(0, 1'b1, n);
        check("start on pickup", 32'h3, {28'h0, outs});
        m = 16'(32'h100 * RESET_RATIO_PCT / FULL_PCT);
        drive(m, 2'h0, 1'b0);
        wait_ticks(2);
        check("hold at release point", 32'h3, {28'h0, outs});
        drive(m - 16'h1, 2'h0, 1'b0);
        wait_bit(0, 1'b0, n);
        check("start cleared on release", 32'h0, {28'h0, outs});
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 1 : $urandom_range(3, 2);
            wr(OFS_FIXED_DLY, 32'(n));
            wr(OFS_CTRL, (k == 2) ? 32'h2 : 32'h0);
            drive(16'($urandom_range(16'h7FFF, 16'h0100)), 2'h0, 1'b0);
            measure(dt);
            check("fixed delay", 32'(n * 5 * CYC), 32'(dt));
            settle();
        end
        wr(OFS_FIXED_DLY, 32'h0);
        drive(16'h0400, 2'h0, 1'b0);
        measure(dt);
        check("instant trip", 32'h0, 32'(dt));
        settle();
        wr(OFS_FIXED_DLY, 32'h8);
        ev = evt_cnt;
        drive(16'h0000, 2'h0, 1'b1);
        wait_ticks(1);
        m = 16'($urandom_range(16'h7FFF, 16'h0100));
        drive(m, 2'h2, 1'b1);
        wait_bit(3, 1'b1, n);
        wait_ticks(2);
        check("blocked without start", 32'h9, {28'h0, outs});
        check("block event count", 32'(ev + 1), 32'(evt_cnt));
        check("block event data", {14'h0, 2'h2, m}, {14'h0, evt_last});
        rdchk(OFS_STATUS, 32'hF);
        settle();
        ev = evt_cnt;
        m = 16'($urandom_range(16'h3FFF, 16'h0100));
        drive(m, 2'h1, 1'b0);
        wait_bit(1, 1'b1, n);
        drive(m + 16'h4000, 2'h1, 1'b0);
        wait_ticks(1);
        drive(m + 16'h4000, 2'h1, 1'b1);
        wait_bit(1, 1'b0, n);
        wait_ticks(1);
        check("start cleared by inhibit", 32'h9, {28'h0, outs});
        check("inhibit event count", 32'(ev + 1), 32'(evt_cnt));
        check("inhibit event data", {14'h0, 2'h1, m}, {14'h0, evt_last});
        settle();
        wr(OFS_INV_TARGET, 32'h100);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_INV_GAIN, 32'(ig[i]));
            wr(OFS_FIXED_DLY, 32'(id[i]));
            wr(OFS_CTRL, 32'(ic[i]));
            drive(16'h0100 + 16'(ix[i]), 2'h0, 1'b0);
            measure(dt);
            ev = inv_ticks(ic[i], ig[i], ix[i], id[i]);
            lo = (ev - 1) * CYC;
            if (id[i] * 5 * CYC > lo) lo = id[i] * 5 * CYC;
            check("inverse delay window", 32'h1, {31'h0, dt >= lo && dt <= ev * CYC});
            settle();
        end
        end_of_test();
    end

    // whole run takes little more than a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_of_test();
    end
endmodule
